// [logic/bsp_pkg.sv]
package bsp_pkg;
  // ------------------------------------------------------------
  // Clock and rate limits
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS      = 10000;
  localparam int MIN_CPU_PERIODS    = 2;
  localparam int MAX_RATE_PERIOD_PS = 13300;
  localparam int P2P_PERIOD_PS      = 15000;
  localparam int EXT_MIN_CYCLES     = (MAX_RATE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int P2P_MIN_CYCLES     = (P2P_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_BIT_CYCLES     = (EXT_MIN_CYCLES > MIN_CPU_PERIODS) ? EXT_MIN_CYCLES : MIN_CPU_PERIODS;
  localparam int P2P_BIT_CYCLES     = (P2P_MIN_CYCLES > MIN_CPU_PERIODS) ? P2P_MIN_CYCLES : MIN_CPU_PERIODS;

  // ------------------------------------------------------------
  // First-bit extra delay, in CPU periods
  // ------------------------------------------------------------
  localparam int FIRST_BIT_DELAY_MIN_P = 2;
  localparam int FIRST_BIT_DELAY_MAX_P = 4;
  localparam logic [2:0] FIRST_BIT_DELAY_CYCLES = 3'((FIRST_BIT_DELAY_MIN_P + FIRST_BIT_DELAY_MAX_P) / 2);

  // ------------------------------------------------------------
  // Field encodings, pin slots, reset values
  // ------------------------------------------------------------
  localparam int DIV_W = 8;
  localparam logic [1:0] DELAY_0 = 2'h0;
  localparam logic [1:0] DELAY_1 = 2'h1;
  localparam logic [1:0] DELAY_2 = 2'h2;
  localparam int PIN_EXT = 0;
  localparam int PIN_RXC = 1;
  localparam int PIN_TXC = 2;
  localparam int PIN_RXF = 3;
  localparam int PIN_TXF = 4;
  localparam int PIN_RXD = 5;
  localparam int PIN_N   = 6;
  localparam logic [7:0] RST_PERIOD_CNT = 8'h00;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_DELAY  = 2'b01,
    TX_LAUNCH = 2'b10,
    TX_SHIFT  = 2'b11
  } bsp_tx_state_e;
endpackage : bsp_pkg

// [logic/bsp_gen_if.sv]
`timescale 1ns/1ps
interface bsp_gen_if;
  import bsp_pkg::*;
  logic             src_cpu;
  logic [DIV_W-1:0] divider;
  logic             ext_rise;
  logic             gen_level;
  logic             gen_rise;
  logic             gen_fall;
  modport gen  (input src_cpu, divider, ext_rise, output gen_level, gen_rise, gen_fall);
  modport user (output src_cpu, divider, ext_rise, input gen_level, gen_rise, gen_fall);
endinterface : bsp_gen_if

// [logic/bsp_clk_gen.sv]
`timescale 1ns/1ps
module bsp_clk_gen
  import bsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  bsp_gen_if.gen   g
);
  // ------------------------------------------------------------
  // Phase lengths in half input periods
  // ------------------------------------------------------------
  logic [DIV_W:0] half_hi;
  logic [DIV_W:0] half_lo;
  logic [DIV_W:0] target;
  logic [DIV_W:0] cnt;
  logic           tick;
  logic           level;

  always_comb begin
    if (g.divider == '0) begin
      half_hi = (DIV_W+1)'(1);
      half_lo = (DIV_W+1)'(1);
    end else if (!g.divider[0]) begin
      half_hi = {1'b0, g.divider} + (DIV_W+1)'(2);
      half_lo = {1'b0, g.divider};
    end else begin
      half_hi = {1'b0, g.divider} + (DIV_W+1)'(1);
      half_lo = {1'b0, g.divider} + (DIV_W+1)'(1);
    end
  end

  // CPU source: one half period is one clk; external: whole ticks only
  always_comb begin
    if (g.src_cpu) begin
      target = level ? half_hi : half_lo;
    end else begin
      target = ((level ? half_hi : half_lo) + (DIV_W+1)'(1)) >> 1;
    end
  end

  assign tick = g.src_cpu ? 1'b1 : g.ext_rise;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt        <= (DIV_W+1)'(1);
      level      <= 1'b0;
      g.gen_rise <= 1'b0;
      g.gen_fall <= 1'b0;
    end else begin
      g.gen_rise <= 1'b0;
      g.gen_fall <= 1'b0;
      if (tick) begin
        if (cnt >= target) begin
          cnt        <= (DIV_W+1)'(1);
          level      <= ~level;
          g.gen_rise <= ~level;
          g.gen_fall <= level;
        end else begin
          cnt <= cnt + (DIV_W+1)'(1);
        end
      end
    end
  end

  assign g.gen_level = level;
endmodule : bsp_clk_gen

// [logic/bsp_serial_port.sv]
`timescale 1ns/1ps
module bsp_serial_port
  import bsp_pkg::*;
#(
  parameter int WORD_BITS  = 8,
  parameter int FRAME_BITS = 16
)(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 gen_clock_source_sel,
  input  wire logic [DIV_W-1:0]     bit_clock_divider,
  input  wire logic                 rx_clock_polarity,
  input  wire logic                 tx_clock_polarity,
  input  wire logic                 rx_frame_polarity,
  input  wire logic                 tx_frame_polarity,
  input  wire logic                 rx_clock_dir,
  input  wire logic                 tx_clock_dir,
  input  wire logic                 rx_frame_dir,
  input  wire logic                 tx_frame_dir,
  input  wire logic [1:0]           rx_data_delay,
  input  wire logic [1:0]           tx_data_delay,
  input  wire logic                 tx_first_bit_delay_en,
  input  wire logic                 frame_resync_en,
  input  wire logic                 ext_clock_in,
  input  wire logic                 rx_bit_clock_in,
  output logic                      rx_bit_clock_out,
  output logic                      rx_bit_clock_oe,
  input  wire logic                 tx_bit_clock_in,
  output logic                      tx_bit_clock_out,
  output logic                      tx_bit_clock_oe,
  input  wire logic                 rx_frame_sync_in,
  output logic                      rx_frame_sync_out,
  output logic                      rx_frame_sync_oe,
  input  wire logic                 tx_frame_sync_in,
  output logic                      tx_frame_sync_out,
  output logic                      tx_frame_sync_oe,
  input  wire logic                 serial_rx_data,
  output logic                      serial_tx_data,
  output logic                      serial_tx_data_oe,
  input  wire logic [WORD_BITS-1:0] tx_word,
  output logic                      tx_word_taken,
  output logic [WORD_BITS-1:0]      rx_word,
  output logic                      rx_word_valid,
  output logic                      port_to_port_mode,
  output logic                      rate_fault
);
  localparam int BC_W = $clog2(WORD_BITS + 1);
  localparam int FC_W = $clog2(FRAME_BITS);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1;
  logic [PIN_N-1:0] s2;
  logic [PIN_N-1:0] s3;
  logic [PIN_N-1:0] filt;
  logic [PIN_N-1:0] filt_q;

  assign pin_raw = {serial_rx_data, tx_frame_sync_in, rx_frame_sync_in,
                    tx_bit_clock_in, rx_bit_clock_in, ext_clock_in};

  // A change only counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < PIN_N; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          s1[i]     <= 1'b0;
          s2[i]     <= 1'b0;
          s3[i]     <= 1'b0;
          filt[i]   <= 1'b0;
          filt_q[i] <= 1'b0;
        end else begin
          s1[i]     <= pin_raw[i];
          s2[i]     <= s1[i];
          s3[i]     <= s2[i];
          filt_q[i] <= filt[i];
          if (s2[i] == s3[i]) begin
            filt[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Bit clock generator
  // ------------------------------------------------------------
  bsp_gen_if gif ();

  assign gif.src_cpu  = gen_clock_source_sel;
  assign gif.divider  = bit_clock_divider;
  assign gif.ext_rise = filt[PIN_EXT] & ~filt_q[PIN_EXT];

  bsp_clk_gen u_gen (
    .clk     (clk),
    .reset_n (reset_n),
    .g       (gif)
  );

  // ------------------------------------------------------------
  // Internal clock views and edges
  // ------------------------------------------------------------
  logic txc;
  logic txc_q;
  logic rxc;
  logic rxc_q;
  logic tx_rise;
  logic tx_fall;
  logic rx_fall;
  logic ext_rise;

  assign ext_rise = gif.ext_rise;
  assign txc = tx_clock_dir ? gif.gen_level : (filt[PIN_TXC] ^ tx_clock_polarity);
  assign rxc = rx_clock_dir ? gif.gen_level : (filt[PIN_RXC] ^ rx_clock_polarity);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txc_q <= 1'b0;
      rxc_q <= 1'b0;
    end else begin
      txc_q <= txc;
      rxc_q <= rxc;
    end
  end

  assign tx_rise = txc & ~txc_q;
  assign tx_fall = ~txc & txc_q;
  assign rx_fall = ~rxc & rxc_q;

  // ------------------------------------------------------------
  // Internal frame sync
  // ------------------------------------------------------------
  logic [FC_W-1:0] fcnt;
  logic            fs_gen;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fcnt   <= '0;
      fs_gen <= 1'b0;
    end else if (tx_rise) begin
      fs_gen <= (fcnt == '0);
      fcnt   <= (fcnt == FC_W'(FRAME_BITS - 1)) ? '0 : fcnt + FC_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Transmit frame detection
  // ------------------------------------------------------------
  logic txf_lvl;
  logic txf_q;
  logic tx_start;

  assign txf_lvl = filt[PIN_TXF] ^ tx_frame_polarity;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txf_q <= 1'b0;
    end else if (tx_fall) begin
      txf_q <= txf_lvl;
    end
  end

  always_comb begin
    if (tx_frame_dir) begin
      tx_start = tx_rise & (fcnt == '0);
    end else if (tx_data_delay == DELAY_0) begin
      // Zero delay: first bit follows the sync edge, not the clock
      tx_start = txf_lvl & ~(filt_q[PIN_TXF] ^ tx_frame_polarity);
    end else begin
      tx_start = tx_fall & txf_lvl & ~txf_q;
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  bsp_tx_state_e            tx_state;
  logic [WORD_BITS-1:0]     tx_sh;
  logic [BC_W-1:0]          tx_left;
  logic [1:0]               tx_dly;
  logic [2:0]               tx_wait;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_state          <= TX_IDLE;
      tx_sh             <= '0;
      tx_left           <= '0;
      tx_dly            <= 2'h0;
      tx_wait           <= 3'h0;
      tx_word_taken     <= 1'b0;
      serial_tx_data    <= 1'b0;
      serial_tx_data_oe <= 1'b0;
    end else begin
      tx_word_taken <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (tx_start) begin
            tx_sh         <= tx_word;
            tx_left       <= BC_W'(WORD_BITS);
            tx_word_taken <= 1'b1;
            tx_dly        <= tx_data_delay;
            tx_wait       <= FIRST_BIT_DELAY_CYCLES;
            tx_state      <= (tx_data_delay == DELAY_0) ? TX_LAUNCH : TX_DELAY;
          end
        end
        TX_DELAY: begin
          if (tx_rise) begin
            tx_dly <= tx_dly - 2'h1;
            if (tx_dly == DELAY_1) begin
              tx_state <= TX_LAUNCH;
            end
          end
        end
        TX_LAUNCH: begin
          // Extra hold only on the first bit of the frame
          if (tx_first_bit_delay_en && tx_wait != 3'h0) begin
            tx_wait <= tx_wait - 3'h1;
          end else begin
            serial_tx_data    <= tx_sh[WORD_BITS-1];
            serial_tx_data_oe <= 1'b1;
            tx_sh             <= {tx_sh[WORD_BITS-2:0], 1'b0};
            tx_left           <= tx_left - BC_W'(1);
            tx_state          <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_rise) begin
            if (tx_left == '0) begin
              serial_tx_data_oe <= 1'b0;
              tx_state          <= TX_IDLE;
            end else begin
              serial_tx_data <= tx_sh[WORD_BITS-1];
              tx_sh          <= {tx_sh[WORD_BITS-2:0], 1'b0};
              tx_left        <= tx_left - BC_W'(1);
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receive frame detection
  // ------------------------------------------------------------
  logic rxf_resync;
  logic rxf_src;
  logic rxf_q;
  logic rx_start;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxf_resync <= 1'b0;
    end else if (ext_rise) begin
      rxf_resync <= filt[PIN_RXF] ^ rx_frame_polarity;
    end
  end

  always_comb begin
    if (rx_frame_dir) begin
      rxf_src = fs_gen;
    end else if (frame_resync_en) begin
      rxf_src = rxf_resync;
    end else begin
      rxf_src = filt[PIN_RXF] ^ rx_frame_polarity;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxf_q <= 1'b0;
    end else if (rx_fall) begin
      rxf_q <= rxf_src;
    end
  end

  assign rx_start = rx_fall & rxf_src & ~rxf_q;

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  logic                 rx_busy;
  logic [1:0]           rx_dly;
  logic [BC_W-1:0]      rx_left;
  logic [WORD_BITS-1:0] rx_sh;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_busy       <= 1'b0;
      rx_dly        <= 2'h0;
      rx_left       <= '0;
      rx_sh         <= '0;
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (rx_start && !rx_busy) begin
        rx_busy <= 1'b1;
        rx_left <= BC_W'(WORD_BITS);
        rx_dly  <= rx_data_delay;
        if (rx_data_delay == DELAY_0) begin
          rx_sh   <= {rx_sh[WORD_BITS-2:0], filt[PIN_RXD]};
          rx_left <= BC_W'(WORD_BITS - 1);
        end
      end else if (rx_busy && rx_fall) begin
        if (rx_dly != DELAY_0) begin
          rx_dly <= rx_dly - 2'h1;
          if (rx_dly == DELAY_1) begin
            rx_sh   <= {rx_sh[WORD_BITS-2:0], filt[PIN_RXD]};
            rx_left <= rx_left - BC_W'(1);
          end
        end else if (rx_left != '0) begin
          rx_sh   <= {rx_sh[WORD_BITS-2:0], filt[PIN_RXD]};
          rx_left <= rx_left - BC_W'(1);
        end
      end
      if (rx_busy && rx_left == '0 && rx_dly == DELAY_0) begin
        rx_busy       <= 1'b0;
        rx_word       <= rx_sh;
        rx_word_valid <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Rate check
  // ------------------------------------------------------------
  // Flags a programmed or supplied transmit bit clock below the minimum period
  logic [7:0] per_cnt;
  logic       p2p_now;

  assign p2p_now = tx_clock_dir & tx_frame_dir & ~rx_clock_dir & ~rx_frame_dir &
                   ((tx_data_delay == DELAY_1) | (tx_data_delay == DELAY_2));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      per_cnt           <= RST_PERIOD_CNT;
      rate_fault        <= 1'b0;
      port_to_port_mode <= 1'b0;
    end else begin
      port_to_port_mode <= p2p_now;
      if (tx_rise) begin
        per_cnt    <= RST_PERIOD_CNT;
        rate_fault <= (32'(per_cnt) + 1) < (p2p_now ? P2P_BIT_CYCLES : MIN_BIT_CYCLES);
      end else if (per_cnt != 8'hff) begin
        per_cnt <= per_cnt + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_bit_clock_out  <= 1'b0;
      tx_bit_clock_oe   <= 1'b0;
      rx_bit_clock_out  <= 1'b0;
      rx_bit_clock_oe   <= 1'b0;
      tx_frame_sync_out <= 1'b0;
      tx_frame_sync_oe  <= 1'b0;
      rx_frame_sync_out <= 1'b0;
      rx_frame_sync_oe  <= 1'b0;
    end else begin
      tx_bit_clock_out  <= gif.gen_level ^ tx_clock_polarity;
      tx_bit_clock_oe   <= tx_clock_dir;
      rx_bit_clock_out  <= gif.gen_level ^ rx_clock_polarity;
      rx_bit_clock_oe   <= rx_clock_dir;
      tx_frame_sync_out <= fs_gen ^ tx_frame_polarity;
      tx_frame_sync_oe  <= tx_frame_dir;
      rx_frame_sync_out <= fs_gen ^ rx_frame_polarity;
      rx_frame_sync_oe  <= rx_frame_dir;
    end
  end
endmodule : bsp_serial_port

// [verification/bsp_serial_port_checker.sv]
`timescale 1ns/1ps
module bsp_serial_port_checker
  import bsp_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             gen_clock_source_sel,
  input wire logic [DIV_W-1:0] bit_clock_divider,
  input wire logic             tx_clock_polarity,
  input wire logic             tx_clock_dir,
  input wire logic             tx_frame_dir,
  input wire logic             rx_clock_dir,
  input wire logic             rx_frame_dir,
  input wire logic [1:0]       tx_data_delay,
  input wire logic             tx_first_bit_delay_en,
  input wire logic             tx_bit_clock_out,
  input wire logic             tx_frame_sync_out,
  input wire logic             serial_tx_data,
  input wire logic             serial_tx_data_oe,
  input wire logic             tx_word_taken,
  input wire logic             rx_word_valid,
  input wire logic             port_to_port_mode,
  input wire logic             rate_fault
);
  // ----
  // Settle age and phase counters
  // ----
  logic [16:0] cfg;
  logic [16:0] cfg_q;
  logic [7:0]  age;
  logic [15:0] hi_n;
  logic [15:0] lo_n;
  logic [15:0] exp_h;
  logic [15:0] exp_l;
  logic        quiet;
  logic        p2p;
  assign cfg = {gen_clock_source_sel, bit_clock_divider, tx_clock_polarity, tx_clock_dir, tx_frame_dir,
                rx_clock_dir, rx_frame_dir, tx_data_delay, tx_first_bit_delay_en};
  // Wait out a long settle span, so a mid-period divider change never fires
  assign quiet = age == 8'hff && gen_clock_source_sel && !tx_clock_polarity && tx_clock_dir
                 && bit_clock_divider != 8'h00;
  assign exp_h = bit_clock_divider[0] ? 16'(bit_clock_divider) + 16'h0001 : 16'(bit_clock_divider) + 16'h0002;
  assign exp_l = bit_clock_divider[0] ? 16'(bit_clock_divider) + 16'h0001 : 16'(bit_clock_divider);
  assign p2p = tx_clock_dir && tx_frame_dir && !rx_clock_dir && !rx_frame_dir
               && (tx_data_delay == DELAY_1 || tx_data_delay == DELAY_2);
  always_ff @(posedge clk) begin
    cfg_q <= cfg;
    if (!reset_n || cfg != cfg_q) begin
      age <= 8'h00;
    end else if (age != 8'hff) begin
      age <= age + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    hi_n <= tx_bit_clock_out ? hi_n + 16'h0001 : 16'h0000;
    lo_n <= tx_bit_clock_out ? 16'h0000 : lo_n + 16'h0001;
  end
  // ----
  // Assertions
  // ----
  a_high_width: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(tx_bit_clock_out) && quiet |-> hi_n == exp_h) else $error("tx clock high width wrong");
  a_low_width: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(tx_bit_clock_out) && quiet |-> lo_n == exp_l) else $error("tx clock low width wrong");
  a_data_on_rise: assert property (@(posedge clk) disable iff (!reset_n)
    quiet && !tx_first_bit_delay_en && serial_tx_data_oe && $past(serial_tx_data_oe) && $changed(serial_tx_data)
    |-> tx_bit_clock_out) else $error("tx data moved outside high phase");
  a_release_rise: assert property (@(posedge clk) disable iff (!reset_n)
    quiet && $fell(serial_tx_data_oe) |-> tx_bit_clock_out) else $error("tx data released off rise");
  a_frame_on_rise: assert property (@(posedge clk) disable iff (!reset_n)
    quiet && tx_frame_dir && $changed(tx_frame_sync_out) |-> tx_bit_clock_out) else $error("frame moved off rise");
  a_taken_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    tx_word_taken |=> !tx_word_taken) else $error("word taken longer than a cycle");
  a_valid_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    rx_word_valid |=> !rx_word_valid) else $error("rx valid longer than a cycle");
  a_p2p_mode: assert property (@(posedge clk) disable iff (!reset_n)
    age == 8'hff |-> port_to_port_mode == p2p) else $error("port to port flag wrong");
  a_rate_ok: assert property (@(posedge clk) disable iff (!reset_n)
    quiet |-> !rate_fault) else $error("rate fault on legal divider");
endmodule : bsp_serial_port_checker

// [verification/bsp_far_end.sv]
`timescale 1ns/1ps
module bsp_far_end (
  input  wire logic       sclk,
  input  wire logic       fs,
  input  wire logic       sd,
  input  wire logic       sd_oe,
  input  wire logic [1:0] delay,
  input  wire logic [7:0] rx_pat,
  input  wire logic       ext_en,
  output logic            rxd,
  output logic            ext_clk,
  output logic [7:0]      word,
  output logic [7:0]      got
);
  logic hold;
  logic fs_q;
  int   cnt;
  int   ia;
  int   ib;
  initial begin
    rxd = 1'b0;
    ext_clk = 1'b0;
    word = 8'h00;
    got = 8'h00;
    fs_q = 1'b0;
    hold = 1'b0;
    cnt = 99;
  end
  // Released line shows the inverse of its last driven value
  always @(sd or sd_oe) if (sd_oe) hold = sd;
  // Even duty, 60 ns period: well above the rate floor
  always #30 ext_clk = ext_en ? ~ext_clk : 1'b0;
  always @(negedge sclk) begin
    cnt = (fs && !fs_q) ? 0 : cnt + 1;
    fs_q = fs;
    ia = cnt - delay;
    if (ia >= 0 && ia < 8) word[7-ia] = sd_oe ? sd : ~hold;
    if (ia == 7) got = got + 8'h01;
  end
  always @(posedge sclk) begin
    ib = cnt + 1 - delay;
    rxd <= (ib >= 0 && ib < 8) ? rx_pat[7-ib] : ~rxd;
  end
endmodule : bsp_far_end

// [verification/bsp_serial_port_bench.sv]
`timescale 1ns/1ps
module bsp_serial_port_bench;
  import bsp_pkg::*;
  logic             clk;
  logic             reset_n;
  logic             src_sel;
  logic [DIV_W-1:0] div;
  logic             clk_pol;
  logic             rx_cdir;
  logic             rx_fdir;
  logic [1:0]       dly;
  logic             fbd;
  logic             ext_en;
  logic [7:0]       tx_w;
  logic [7:0]       rx_pat;
  wire              txc, txf, txd, txd_oe, rxd, ext_clk, rx_v, p2p, rflt;
  wire  [7:0]       rx_w, word, got;
  int               mismatches;
  int               n_tests;

  bsp_serial_port uut (
    .clk, .reset_n, .gen_clock_source_sel(src_sel), .bit_clock_divider(div),
    .rx_clock_polarity(clk_pol), .tx_clock_polarity(clk_pol), .rx_frame_polarity(1'b0),
    .tx_frame_polarity(1'b0), .rx_clock_dir(rx_cdir), .tx_clock_dir(1'b1), .rx_frame_dir(rx_fdir),
    .tx_frame_dir(1'b1), .rx_data_delay(dly), .tx_data_delay(dly), .tx_first_bit_delay_en(fbd),
    .frame_resync_en(1'b0), .ext_clock_in(ext_clk), .rx_bit_clock_in(txc), .rx_bit_clock_out(),
    .rx_bit_clock_oe(), .tx_bit_clock_in(txc), .tx_bit_clock_out(txc), .tx_bit_clock_oe(),
    .rx_frame_sync_in(txf), .rx_frame_sync_out(), .rx_frame_sync_oe(), .tx_frame_sync_in(txf),
    .tx_frame_sync_out(txf), .tx_frame_sync_oe(), .serial_rx_data(rxd), .serial_tx_data(txd),
    .serial_tx_data_oe(txd_oe), .tx_word(tx_w), .tx_word_taken(), .rx_word(rx_w),
    .rx_word_valid(rx_v), .port_to_port_mode(p2p), .rate_fault(rflt)
  );
  bsp_far_end far (.sclk(txc), .fs(txf), .sd(txd), .sd_oe(txd_oe), .delay(dly), .rx_pat, .ext_en,
                   .rxd, .ext_clk, .word, .got);

  // ----
  // Compare, wait, setup and closing tasks
  // ----
  task automatic chk_n(input int g, input int e);
    n_tests++;
    if (g != e) begin
      mismatches++;
      $display("MISMATCH %0t count %0d expected %0d", $time, g, e);
    end
  endtask : chk_n
  task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask : chk_v
  task automatic test_done;
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic lvl(input logic v, output int n);
    n = 0;
    while (txc !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask : lvl
  task automatic setup(input logic s, input logic [7:0] d, input logic p, input logic [1:0] dl, input logic f);
    @(posedge clk);
    src_sel <= s;
    div <= d;
    clk_pol <= p;
    dly <= dl;
    fbd <= f;
  endtask : setup

  // ----
  // Scenarios
  // ----
  task automatic t_widths(input logic [7:0] d, input logic p, input int s, output int hi, output int lo);
    int n;
    int h;
    int l;
    setup(s == 2, d, p, DELAY_1, 1'b0);
    if (s != 2) ext_en <= 1'b1;
    repeat (120) @(negedge clk);
    lvl(1'b0, n);
    lvl(1'b1, n);
    lvl(1'b0, hi);
    lvl(1'b1, lo);
    h = d[0] ? (d + 1) / 2 * s : (d / 2 + 1) * s;
    l = d[0] ? (d + 1) / 2 * s : d / 2 * s;
    chk_n(hi, p ? l : h);
    chk_n(lo, p ? h : l);
    chk_n(hi + lo, (d + 1) * s);
    ext_en <= 1'b0;
  endtask : t_widths
  task automatic t_xfer(input logic [1:0] dl, input logic f, input logic [7:0] v);
    int k;
    setup(1'b1, 8'h05, 1'b0, dl, f);
    tx_w <= v;
    rx_pat <= ~v;
    // A frame already started holds the old word: judge the second one
    repeat (2) begin
      k = 0;
      while (txd_oe !== 1'b1 && k < 600) begin
        @(negedge clk);
        k++;
      end
      k = 0;
      while (txd_oe === 1'b1 && k < 600) begin
        @(negedge clk);
        k++;
      end
    end
    repeat (8) @(negedge clk);
    chk_v(word, v);
    if (dl != DELAY_0) begin
      k = 0;
      while (rx_v !== 1'b1 && k < 600) begin
        @(negedge clk);
        k++;
      end
      chk_v(rx_w, ~v);
    end
  endtask : t_xfer
  task automatic t_p2p;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      rx_cdir <= 1'b0;
      rx_fdir <= 1'b0;
      dly <= 2'(i);
      repeat (20) @(negedge clk);
      chk_v({7'h00, p2p}, {7'h00, i != 0});
      chk_v({7'h00, rflt}, 8'h00);
    end
  endtask : t_p2p

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
  initial begin
    int hi;
    int lo;
    reset_n = 1'b0;
    {src_sel, clk_pol, fbd, ext_en} = 4'h8;
    {rx_cdir, rx_fdir} = 2'h3;
    div = 8'h01;
    dly = DELAY_1;
    tx_w = 8'h00;
    rx_pat = 8'h00;
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    foreach (div[i]) if (i < 4) t_widths(8'(i + 1 + i / 3), 1'b0, 2, hi, lo);
    t_widths(8'h02, 1'b1, 2, hi, lo);
    t_widths(8'h03, 1'b0, 6, hi, lo);
    t_xfer(DELAY_1, 1'b0, 8'h3c);
    t_xfer(DELAY_0, 1'b1, 8'h96);
    t_xfer(DELAY_2, 1'b1, 8'hc5);
    t_xfer(DELAY_0, 1'b0, 8'h81);
    t_p2p();
    test_done();
  end
endmodule : bsp_serial_port_bench

bind bsp_serial_port bsp_serial_port_checker chk (
  .clk, .reset_n, .gen_clock_source_sel, .bit_clock_divider, .tx_clock_polarity, .tx_clock_dir,
  .tx_frame_dir, .rx_clock_dir, .rx_frame_dir, .tx_data_delay, .tx_first_bit_delay_en,
  .tx_bit_clock_out, .tx_frame_sync_out, .serial_tx_data, .serial_tx_data_oe, .tx_word_taken,
  .rx_word_valid, .port_to_port_mode, .rate_fault
);
